// [hdl/seq_pkg.sv]
// constants for the waveform segment sequencer
// assumes a single 100 MHz clock domain
package seq_pkg;
	localparam int unsigned LIST_DEPTH_STD = 512;
	localparam int unsigned LIST_DEPTH_BIG = 2048;
	localparam int unsigned IDX_W = 11;
	localparam int unsigned CNT_W = 12;
	localparam int unsigned WAVE_W = 8;
	localparam int unsigned LOOP_W = 8;
	localparam int unsigned ADDR_W = 20;
	localparam int unsigned LEN_W = 20;
	localparam int unsigned SAMPLE_W = 16;
	localparam logic [LOOP_W-1:0] LOOP_MAX = 8'hFF;
	localparam logic [LEN_W-1:0] MIN_SEG_LEN = 20'h00040;
	localparam logic [2:0] OP_INSERT = 3'h0;
	localparam logic [2:0] OP_DELETE = 3'h1;
	localparam logic [2:0] OP_BLK_COPY = 3'h2;
	localparam logic [2:0] OP_BLK_DEL = 3'h3;
	localparam logic [2:0] OP_COMPILE = 3'h4;
	localparam logic [2:0] OP_GROUP = 3'h5;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SHIFT = 3'b001,
		ST_LOAD = 3'b010,
		ST_PLAY = 3'b011
	} state_e;
endpackage

// [hdl/seq_core.sv]
// waveform segment sequencer: link list edit and playback
// assumes host keeps loop counts at 255 or less and a waveform table of lengths
`timescale 1ns/10ps
`default_nettype none
module seq_core (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// configuration
	input wire logic big_mem_in,
	// command port
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire logic [2:0] cmd_op_in,
	input wire logic [seq_pkg::IDX_W-1:0] cmd_idx_in,
	input wire logic [seq_pkg::IDX_W-1:0] cmd_blk_first_in,
	input wire logic [seq_pkg::IDX_W-1:0] cmd_blk_last_in,
	input wire logic [seq_pkg::WAVE_W-1:0] cmd_wave_in,
	input wire logic [seq_pkg::LOOP_W-1:0] cmd_loops_in,
	input wire logic [seq_pkg::ADDR_W-1:0] cmd_base_in,
	input wire logic [seq_pkg::LEN_W-1:0] cmd_len_in,
	output logic cmd_refused_out,
	output logic warn_out,
	output logic [seq_pkg::CNT_W-1:0] count_out,
	// sample memory address stream
	output logic addr_valid_out,
	input wire logic addr_ready_in,
	output logic [seq_pkg::ADDR_W-1:0] addr_out,
	output logic [seq_pkg::WAVE_W-1:0] addr_wave_out,
	output logic playing_out
);
	localparam int unsigned ENT_W = seq_pkg::WAVE_W + seq_pkg::LOOP_W
		+ seq_pkg::ADDR_W + seq_pkg::LEN_W;
	localparam int unsigned DEPTH = seq_pkg::LIST_DEPTH_BIG;
	localparam int unsigned OUT_W = seq_pkg::ADDR_W + seq_pkg::WAVE_W;

	// edit list and compiled playback list
	logic [ENT_W-1:0] edit_mem [DEPTH];
	logic [ENT_W-1:0] play_mem [DEPTH];

	seq_pkg::state_e state_reg, state_next;
	seq_pkg::state_e play_reg, play_next;
	logic [seq_pkg::CNT_W-1:0] src_reg, src_next;
	logic [seq_pkg::CNT_W-1:0] count_reg, count_next;
	logic [seq_pkg::CNT_W-1:0] play_cnt_reg, play_cnt_next;
	logic [seq_pkg::CNT_W-1:0] ptr_reg, ptr_next;
	logic [seq_pkg::CNT_W-1:0] stop_reg, stop_next;
	logic [seq_pkg::CNT_W-1:0] nblk_reg, nblk_next;
	logic [seq_pkg::CNT_W-1:0] pidx_reg, pidx_next;
	logic [seq_pkg::LOOP_W-1:0] loop_reg, loop_next;
	logic [seq_pkg::LEN_W-1:0] pos_reg, pos_next;
	logic [ENT_W-1:0] cur_reg, cur_next;
	logic [1:0] mode_reg, mode_next;
	logic [ENT_W-1:0] new_reg, new_next;
	logic refused_reg, refused_next;
	logic warn_reg, warn_next;
	logic mem_we;
	logic [seq_pkg::IDX_W-1:0] mem_wa;
	logic [ENT_W-1:0] mem_wd;
	logic copy_all;

	// two entry output buffer
	logic [OUT_W-1:0] buf_reg [2];
	logic [OUT_W-1:0] buf0_next, buf1_next;
	logic [1:0] fill_reg, fill_next;
	logic push, pop;

	function automatic logic [seq_pkg::CNT_W-1:0] depth_of(input logic big);
		depth_of = big ? seq_pkg::CNT_W'(seq_pkg::LIST_DEPTH_BIG)
			: seq_pkg::CNT_W'(seq_pkg::LIST_DEPTH_STD);
	endfunction

	function automatic logic [seq_pkg::IDX_W-1:0] ix(input logic [seq_pkg::CNT_W-1:0] v);
		ix = v[seq_pkg::IDX_W-1:0];
	endfunction

	assign cmd_ready_out = state_reg == seq_pkg::ST_IDLE;
	assign pop = addr_valid_out && addr_ready_in;
	assign addr_valid_out = fill_reg != 2'h0;
	assign addr_out = buf_reg[0][seq_pkg::ADDR_W-1:0];
	assign addr_wave_out = buf_reg[0][OUT_W-1:seq_pkg::ADDR_W];
	assign push = (play_reg == seq_pkg::ST_PLAY) && (fill_reg != 2'h2 || pop);
	assign count_out = count_reg;
	assign cmd_refused_out = refused_reg;
	assign warn_out = warn_reg;
	assign playing_out = play_reg == seq_pkg::ST_PLAY;

	// modes: 0 insert shift, 1 delete shift, 2 block copy
	always_comb begin
		logic [seq_pkg::CNT_W-1:0] idx;
		logic [seq_pkg::CNT_W-1:0] bf;
		logic [seq_pkg::CNT_W-1:0] bl;
		logic [seq_pkg::CNT_W-1:0] n;
		idx = seq_pkg::CNT_W'(cmd_idx_in);
		bf = seq_pkg::CNT_W'(cmd_blk_first_in);
		bl = seq_pkg::CNT_W'(cmd_blk_last_in);
		n = bl - bf + seq_pkg::CNT_W'(1);
		state_next = state_reg;
		count_next = count_reg;
		ptr_next = ptr_reg;
		stop_next = stop_reg;
		nblk_next = nblk_reg;
		src_next = src_reg;
		mode_next = mode_reg;
		new_next = new_reg;
		refused_next = 1'b0;
		warn_next = 1'b0;
		mem_we = 1'b0;
		mem_wa = '0;
		mem_wd = '0;
		copy_all = 1'b0;
		if (cmd_valid_in && cmd_ready_out) begin
			unique case (cmd_op_in)
				seq_pkg::OP_INSERT: begin
					if (count_reg >= depth_of(big_mem_in) || idx > count_reg
						|| cmd_len_in < seq_pkg::MIN_SEG_LEN || cmd_loops_in == '0) begin
						refused_next = 1'b1;
					end else begin
						new_next = {cmd_wave_in, cmd_loops_in, cmd_base_in, cmd_len_in};
						ptr_next = count_reg;
						stop_next = idx;
						mode_next = 2'h0;
						state_next = seq_pkg::ST_SHIFT;
					end
				end
				seq_pkg::OP_DELETE, seq_pkg::OP_BLK_DEL: begin
					if (cmd_op_in == seq_pkg::OP_DELETE) begin
						bf = idx;
						bl = idx;
						n = seq_pkg::CNT_W'(1);
					end
					if (bl >= count_reg || bf > bl) begin
						refused_next = 1'b1;
					end else begin
						ptr_next = bf;
						nblk_next = n;
						mode_next = 2'h1;
						state_next = seq_pkg::ST_SHIFT;
					end
				end
				seq_pkg::OP_BLK_COPY: begin
					// copy source must lie before the target so shifting keeps it intact
					if (bl >= count_reg || bf > bl || idx > count_reg || bl >= idx
						|| count_reg + n > depth_of(big_mem_in)) begin
						refused_next = 1'b1;
					end else begin
						ptr_next = count_reg + n - seq_pkg::CNT_W'(1);
						stop_next = idx + n;
						nblk_next = n;
						src_next = bf;
						mode_next = 2'h2;
						state_next = seq_pkg::ST_SHIFT;
					end
				end
				seq_pkg::OP_COMPILE: begin
					copy_all = 1'b1;
				end
				seq_pkg::OP_GROUP: begin
					warn_next = 1'b1;
				end
				default: begin
					refused_next = 1'b1;
				end
			endcase
		end else begin
			unique case (state_reg)
				seq_pkg::ST_IDLE: begin
				end
				seq_pkg::ST_SHIFT: begin
					if (mode_reg == 2'h0) begin
						if (ptr_reg == stop_reg) begin
							mem_we = 1'b1;
							mem_wa = ix(ptr_reg);
							mem_wd = new_reg;
							count_next = count_reg + seq_pkg::CNT_W'(1);
							state_next = seq_pkg::ST_IDLE;
						end else begin
							mem_we = 1'b1;
							mem_wa = ix(ptr_reg);
							mem_wd = edit_mem[ix(ptr_reg - seq_pkg::CNT_W'(1))];
							ptr_next = ptr_reg - seq_pkg::CNT_W'(1);
						end
					end else if (mode_reg == 2'h1) begin
						if (ptr_reg + nblk_reg >= count_reg) begin
							count_next = count_reg - nblk_reg;
							state_next = seq_pkg::ST_IDLE;
						end else begin
							mem_we = 1'b1;
							mem_wa = ix(ptr_reg);
							mem_wd = edit_mem[ix(ptr_reg + nblk_reg)];
							ptr_next = ptr_reg + seq_pkg::CNT_W'(1);
						end
					end else begin
						mem_we = 1'b1;
						mem_wa = ix(ptr_reg);
						if (ptr_reg >= stop_reg) begin
							mem_wd = edit_mem[ix(ptr_reg - nblk_reg)];
						end else begin
							mem_wd = edit_mem[ix(src_reg + ptr_reg + nblk_reg - stop_reg)];
						end
						if (ptr_reg == stop_reg - nblk_reg) begin
							count_next = count_reg + nblk_reg;
							state_next = seq_pkg::ST_IDLE;
						end else begin
							ptr_next = ptr_reg - seq_pkg::CNT_W'(1);
						end
					end
				end
				default: begin
					state_next = seq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// playback runs beside editing, so edits never disturb the output
	always_comb begin
		play_next = play_reg;
		play_cnt_next = play_cnt_reg;
		pidx_next = pidx_reg;
		loop_next = loop_reg;
		pos_next = pos_reg;
		cur_next = cur_reg;
		if (copy_all) begin
			play_cnt_next = count_reg;
			pidx_next = '0;
			play_next = (count_reg == '0) ? seq_pkg::ST_IDLE : seq_pkg::ST_LOAD;
		end else begin
			unique case (play_reg)
				seq_pkg::ST_IDLE: begin
				end
				seq_pkg::ST_LOAD: begin
					cur_next = play_mem[ix(pidx_reg)];
					loop_next = '0;
					pos_next = '0;
					play_next = seq_pkg::ST_PLAY;
				end
				seq_pkg::ST_PLAY: begin
					if (push) begin
						pos_next = pos_reg + seq_pkg::LEN_W'(1);
						if (pos_reg == cur_reg[seq_pkg::LEN_W-1:0] - seq_pkg::LEN_W'(1)) begin
							pos_next = '0;
							loop_next = loop_reg + seq_pkg::LOOP_W'(1);
							if (loop_reg + seq_pkg::LOOP_W'(1) == cur_reg[ENT_W-seq_pkg::WAVE_W-1 -: seq_pkg::LOOP_W]) begin
								pidx_next = (pidx_reg + seq_pkg::CNT_W'(1) == play_cnt_reg)
									? '0 : pidx_reg + seq_pkg::CNT_W'(1);
								play_next = seq_pkg::ST_LOAD;
							end
						end
					end
				end
				default: begin
					play_next = seq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// buffer next state
	always_comb begin
		logic [OUT_W-1:0] word;
		word = {cur_reg[ENT_W-1 -: seq_pkg::WAVE_W],
			cur_reg[seq_pkg::LEN_W +: seq_pkg::ADDR_W] + seq_pkg::ADDR_W'(pos_reg)};
		buf0_next = buf_reg[0];
		buf1_next = buf_reg[1];
		fill_next = fill_reg;
		if (copy_all) begin
			// compile drops words of the old sequence
			fill_next = '0;
		end else if (pop) begin
			buf0_next = buf_reg[1];
			fill_next = fill_reg - 2'h1;
		end
		if (push && !copy_all) begin
			if (fill_next == 2'h0) begin
				buf0_next = word;
			end else begin
				buf1_next = word;
			end
			fill_next = fill_next + 2'h1;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= seq_pkg::ST_IDLE;
			play_reg <= seq_pkg::ST_IDLE;
			src_reg <= '0;
			count_reg <= '0;
			play_cnt_reg <= '0;
			ptr_reg <= '0;
			stop_reg <= '0;
			nblk_reg <= '0;
			pidx_reg <= '0;
			loop_reg <= '0;
			pos_reg <= '0;
			cur_reg <= '0;
			mode_reg <= '0;
			new_reg <= '0;
			refused_reg <= 1'b0;
			warn_reg <= 1'b0;
			buf_reg[0] <= '0;
			buf_reg[1] <= '0;
			fill_reg <= '0;
		end else begin
			state_reg <= state_next;
			play_reg <= play_next;
			src_reg <= src_next;
			count_reg <= count_next;
			play_cnt_reg <= play_cnt_next;
			ptr_reg <= ptr_next;
			stop_reg <= stop_next;
			nblk_reg <= nblk_next;
			pidx_reg <= pidx_next;
			loop_reg <= loop_next;
			pos_reg <= pos_next;
			cur_reg <= cur_next;
			mode_reg <= mode_next;
			new_reg <= new_next;
			refused_reg <= refused_next;
			warn_reg <= warn_next;
			buf_reg[0] <= buf0_next;
			buf_reg[1] <= buf1_next;
			fill_reg <= fill_next;
		end
	end

	// list storage has no reset; count_reg marks what is valid in edit_mem, play_cnt_reg in play_mem
	always_ff @(posedge clk_in) begin
		if (mem_we) begin
			edit_mem[mem_wa] <= mem_wd;
		end
		if (copy_all) begin
			play_mem <= edit_mem;
		end
	end
endmodule
`default_nettype wire

// [bench/seq_monitor.sv]
// checker for the sequencer command and address ports
// assumes one clock domain, bound to every seq_core
`timescale 1ns/10ps
`default_nettype none
module seq_monitor (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// command side
	input wire logic big_mem_in,
	input wire logic cmd_valid_in,
	input wire logic cmd_ready_out,
	input wire logic [2:0] cmd_op_in,
	input wire logic [10:0] cmd_idx_in,
	input wire logic [10:0] cmd_blk_first_in,
	input wire logic [10:0] cmd_blk_last_in,
	input wire logic [7:0] cmd_loops_in,
	input wire logic [19:0] cmd_len_in,
	input wire logic cmd_refused_out,
	input wire logic warn_out,
	input wire logic [11:0] count_out,
	// address stream
	input wire logic addr_valid_out,
	input wire logic addr_ready_in,
	input wire logic [19:0] addr_out,
	input wire logic [7:0] addr_wave_out
);
	wire logic take = cmd_valid_in && cmd_ready_out;
	wire logic ins = take && cmd_op_in == seq_pkg::OP_INSERT;
	wire logic grp = take && cmd_op_in == seq_pkg::OP_GROUP;
	wire logic [11:0] depth = big_mem_in ? 12'h800 : 12'h200;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	AST_WARN: assert property (grp |=> warn_out)
		else $error("group command gave no warning");
	AST_WARN_CAUSE: assert property (warn_out |-> $past(grp))
		else $error("warning without group command");
	AST_LOOPS_ZERO: assert property (ins && cmd_loops_in == 8'h00 |=> cmd_refused_out)
		else $error("zero loop count accepted");
	AST_SHORT_SEG: assert property (ins && cmd_len_in < 20'h00040 |=> cmd_refused_out)
		else $error("short segment accepted");
	AST_BAD_IDX: assert property (ins && {1'b0, cmd_idx_in} > count_out |=> cmd_refused_out)
		else $error("insert past list end accepted");
	AST_FULL: assert property (ins && count_out >= depth |=> cmd_refused_out)
		else $error("insert into full list accepted");
	AST_DEPTH: assert property (count_out <= depth)
		else $error("entry count above list depth");
	AST_BLK_RANGE: assert property (take && cmd_op_in == seq_pkg::OP_BLK_DEL
		&& cmd_blk_first_in > cmd_blk_last_in |=> cmd_refused_out)
		else $error("reversed block range accepted");
	AST_REF_CAUSE: assert property (cmd_refused_out |-> $past(take))
		else $error("refusal without a command");
	AST_HOLD: assert property (addr_valid_out && !addr_ready_in
		&& !(take && cmd_op_in == seq_pkg::OP_COMPILE) |=> addr_valid_out
		&& $stable(addr_out) && $stable(addr_wave_out))
		else $error("stalled address word lost");
endmodule
bind seq_core seq_monitor mon (.clk_in, .rstn_in, .big_mem_in, .cmd_valid_in, .cmd_ready_out,
	.cmd_op_in, .cmd_idx_in, .cmd_blk_first_in, .cmd_blk_last_in, .cmd_loops_in, .cmd_len_in,
	.cmd_refused_out, .warn_out, .count_out, .addr_valid_out, .addr_ready_in, .addr_out,
	.addr_wave_out);
`default_nettype wire

// [bench/addr_sink.sv]
// sample address consumer model
// assumes the sequencer holds a word until it is taken
`timescale 1ns/10ps
`default_nettype none
module addr_sink (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// stream control
	input wire logic hold_in,
	output logic ready_out
);
	logic [1:0] tick_reg;
	logic [1:0] tick_next;
	// one stall in four so the buffer really fills
	always_comb tick_next = tick_reg + 2'h1;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) tick_reg <= 2'h0;
		else tick_reg <= tick_next;
	end
	assign ready_out = !hold_in && tick_reg != 2'h3;
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// bench for the segment sequencer: edits, refusals and playback order
// assumes addr_sink as the consumer of the address stream
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
	localparam logic [19:0] sl = seq_pkg::MIN_SEG_LEN;
	logic clk_in = 0, rstn_in = 0, v = 0, hold = 1, rdy, ref_o, warn_o, av, ar, pl;
	logic [2:0] op = 3'h0;
	logic [10:0] idx = 11'h000, fst = 11'h000, lst = 11'h000;
	logic [7:0] wv = 8'h00, lp = 8'h00, aw;
	logic [19:0] bs = 20'h00000, ln = 20'h00000, ad;
	logic [11:0] cnt;
	int n_errors = 0, n_checks = 0;
	always #5 clk_in = ~clk_in;
	seq_core uut (.clk_in, .rstn_in, .big_mem_in(1'b0), .cmd_valid_in(v), .cmd_ready_out(rdy),
		.cmd_op_in(op), .cmd_idx_in(idx), .cmd_blk_first_in(fst), .cmd_blk_last_in(lst),
		.cmd_wave_in(wv), .cmd_loops_in(lp), .cmd_base_in(bs), .cmd_len_in(ln),
		.cmd_refused_out(ref_o), .warn_out(warn_o), .count_out(cnt), .addr_valid_out(av),
		.addr_ready_in(ar), .addr_out(ad), .addr_wave_out(aw), .playing_out(pl));
	addr_sink sink (.clk_in, .rstn_in, .hold_in(hold), .ready_out(ar));
	task automatic cmd(input logic [2:0] o, input logic [10:0] i, f, e,
			input logic [7:0] w, l, input logic [19:0] n, input logic r);
		@(posedge clk_in);
		op <= o;
		idx <= i;
		fst <= f;
		lst <= e;
		wv <= w;
		lp <= l;
		bs <= {w, 12'h000};
		ln <= n;
		v <= 1'b1;
		do @(negedge clk_in); while (rdy !== 1'b1);
		@(posedge clk_in);
		v <= 1'b0;
		@(negedge clk_in);
		`CHK(ref_o, r)
		`CHK(warn_o, 1'(o == seq_pkg::OP_GROUP))
	endtask
	task automatic ins(input logic [10:0] i, input logic [7:0] w, l,
			input logic [19:0] n, input logic r);
		cmd(seq_pkg::OP_INSERT, i, i, i, w, l, n, r);
	endtask
	task automatic cnt_is(input logic [11:0] e);
		do @(negedge clk_in); while (rdy !== 1'b1);
		`CHK(cnt, e)
	endtask
	task automatic pop();
		do @(negedge clk_in); while (!(av === 1'b1 && ar === 1'b1));
	endtask
	task automatic seg(input logic [7:0] w, input int n, input int s);
		for (int k = s; k < n * 64; k++) begin
			pop();
			`CHK(ad, {w, 12'h000} + 20'(k % 64))
			`CHK(aw, w)
		end
	endtask
	// words of the still running playback may precede the wanted segment; compile leaves no stale buffered words
	task automatic find(input logic [7:0] w);
		do pop(); while (aw !== w);
		`CHK(ad, {w, 12'h000})
		`CHK(pl, 1'b1)
	endtask
	task automatic t_refuse();
		ins(0, 8'h01, 8'h00, sl, 1);
		ins(0, 8'h01, 8'h01, sl - 20'h1, 1);
		ins(1, 8'h01, 8'h01, sl, 1);
		cmd(3'h6, 0, 0, 0, 8'h01, 8'h01, sl, 1);
		cmd(seq_pkg::OP_DELETE, 0, 0, 0, 8'h01, 8'h01, sl, 1);
		cmd(seq_pkg::OP_BLK_DEL, 0, 1, 0, 8'h01, 8'h01, sl, 1);
		cmd(seq_pkg::OP_GROUP, 0, 0, 0, 8'h01, 8'h01, sl, 0);
		cnt_is(12'h000);
	endtask
	task automatic t_full();
		for (int i = 0; i < 512; i++) ins(11'(i), 8'h10, 8'hFF, sl, 0);
		cnt_is(12'h200);
		ins(0, 8'h10, 8'h01, sl, 1);
		cmd(seq_pkg::OP_BLK_DEL, 0, 0, 511, 8'h10, 8'h01, sl, 0);
		cnt_is(12'h000);
	endtask
	task automatic t_play();
		ins(0, 8'hA1, 8'h02, sl, 0);
		ins(1, 8'hC3, 8'h01, sl, 0);
		ins(1, 8'hB2, 8'h01, sl, 0);
		cnt_is(12'h003);
		cmd(seq_pkg::OP_COMPILE, 0, 0, 0, 8'h00, 8'h01, sl, 0);
		hold <= 1'b0;
		find(8'hA1);
		seg(8'hA1, 2, 1);
		seg(8'hB2, 1, 0);
		seg(8'hC3, 1, 0);
		hold <= 1'b1;
		cmd(seq_pkg::OP_DELETE, 1, 1, 1, 8'h00, 8'h01, sl, 0);
		cnt_is(12'h002);
		hold <= 1'b0;
		find(8'hA1);
		seg(8'hA1, 2, 1);
		seg(8'hB2, 1, 0);
		seg(8'hC3, 1, 0);
		cmd(seq_pkg::OP_COMPILE, 0, 0, 0, 8'h00, 8'h01, sl, 0);
		find(8'hA1);
		seg(8'hA1, 2, 1);
		seg(8'hC3, 1, 0);
		seg(8'hA1, 2, 0);
	endtask
	task automatic t_block();
		cmd(seq_pkg::OP_BLK_COPY, 2, 0, 0, 8'h00, 8'h01, sl, 0);
		cnt_is(12'h003);
		cmd(seq_pkg::OP_BLK_COPY, 0, 0, 0, 8'h00, 8'h01, sl, 1);
		cmd(seq_pkg::OP_COMPILE, 0, 0, 0, 8'h00, 8'h01, sl, 0);
		find(8'hA1);
		seg(8'hA1, 2, 1);
		seg(8'hC3, 1, 0);
		seg(8'hA1, 2, 0);
		cmd(seq_pkg::OP_BLK_DEL, 0, 1, 2, 8'h00, 8'h01, sl, 0);
		cnt_is(12'h001);
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_in);
		rstn_in <= 1'b1;
		t_refuse();
		t_full();
		t_play();
		t_block();
		report_and_stop();
	end
	// well above the few thousand cycles the scenarios need
	initial begin
		#500000;
		n_errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
